// File: loop_string_exec_unit.sv
// Loop, count-zero branch, software trap and single string element unit
//
// Notes on behaviour
// - Loops decrement the count first, only its low 16 bits under 16-bit addressing.
// - Branch target is instruction pointer plus signed displacement, wrapping in segment.
// - Decremented count of zero means no branch; fall through to next instruction.
// - A zero count wraps to all ones, so the loop runs the full range.
// - Loop-while-equal branches only on nonzero count with zero flag set.
// - Loop-while-not-equal branches only on nonzero count with zero flag clear.
// - Count-zero jump tests the full count, branches on zero, never changes it.
// - Under 16-bit addressing the count-zero jump tests only the low 16 bits.
// - Software interrupt raises the vector carried by the instruction, any vector.
// - Overflow trap raises the overflow exception only when the overflow flag is set.
// - Range check raises its exception when value is below lower or above upper.
// - String operations work on one byte, word or doubleword at the index offsets.
// - Source uses data segment by default; an override picks any other segment.
// - Destination always uses the extra segment; overrides are ignored for it.
// - String move reads the source element and writes it to the destination.
// - String compare subtracts destination from source, sets six flags, writes nothing.
// - String scan subtracts destination from the accumulator part, sets flags only.
// - String load puts the source element into the size-matched accumulator part.
// - String store writes the size-matched accumulator part at the destination.
// - Each element steps the used indexes by its size, down when direction set.
`timescale 1ns/10ps
`include "lsx_params.svh"

module loop_string_exec_unit (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_b,
   // Request, held stable until o_done
   input  wire logic                 i_start,
   input  wire lsx_pkg::op_t         i_op,
   input  wire lsx_pkg::elem_size_t  i_size,
   input  wire lsx_pkg::seg_sel_t    i_seg_ovr,
   input  wire logic                 i_addr16,
   input  wire logic [7:0]           i_vector,
   input  wire logic [31:0]          i_disp,
   // Architectural state in
   input  wire logic [31:0]          i_instr_pointer,
   input  wire logic [31:0]          i_loop_count_reg,
   input  wire logic                 i_zero_flag,
   input  wire logic                 i_overflow_flag,
   input  wire logic                 i_direction_flag,
   input  wire logic [31:0]          i_source_index,
   input  wire logic [31:0]          i_dest_index_reg,
   input  wire logic [31:0]          i_accum_dword,
   input  wire logic [31:0]          i_bound_val,
   input  wire logic [31:0]          i_bound_lo,
   input  wire logic [31:0]          i_bound_hi,
   // Segment base addresses
   input  wire logic [31:0]          i_data_segment_reg,
   input  wire logic [31:0]          i_code_segment_reg,
   input  wire logic [31:0]          i_stack_segment_reg,
   input  wire logic [31:0]          i_extra_segment_reg,
   input  wire logic [31:0]          i_aux_segment_f_reg,
   input  wire logic [31:0]          i_aux_segment_g_reg,
   // Memory port
   output logic                      o_mem_req,
   output logic                      o_mem_we,
   output lsx_pkg::elem_size_t       o_mem_size,
   output logic [31:0]               o_mem_addr,
   output logic [31:0]               o_mem_wdata,
   input  wire logic                 i_mem_ack,
   input  wire logic [31:0]          i_mem_rdata,
   // Results
   output logic                      o_done,
   output logic                      o_branch,
   output logic [31:0]               o_instr_pointer,
   output logic [31:0]               o_loop_count_reg,
   output logic                      o_count_we,
   output logic [31:0]               o_accum_dword,
   output logic                      o_accum_we,
   output logic [5:0]                o_flags,
   output logic                      o_flags_we,
   output logic                      o_exc,
   output logic [7:0]                o_exc_vector,
   output logic [31:0]               o_source_index,
   output logic                      o_src_we,
   output logic [31:0]               o_dest_index_reg,
   output logic                      o_dst_we
);
   import lsx_pkg::*;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] size_mask(elem_size_t s);
      case (s)
         SZ_BYTE: return 32'h0000_00FF;
         SZ_WORD: return 32'h0000_FFFF;
         default: return 32'hFFFF_FFFF;
      endcase
   endfunction

   function automatic logic [31:0] size_step(elem_size_t s);
      case (s)
         SZ_BYTE: return 32'h0000_0001;
         SZ_WORD: return 32'h0000_0002;
         default: return 32'h0000_0004;
      endcase
   endfunction

   // Borrow taken on masked operands, so byte and word results match a
   // plain subtract of that width
   function automatic logic [5:0] sub_flags(logic [31:0] a, logic [31:0] b,
                                            elem_size_t s);
      logic [31:0] am;
      logic [31:0] bm;
      logic [31:0] r;
      logic [4:0]  hb;
      logic [5:0]  f;
      am = a & size_mask(s);
      bm = b & size_mask(s);
      r  = (am - bm) & size_mask(s);
      hb = (s == SZ_BYTE) ? 5'h07 : (s == SZ_WORD) ? 5'h0F : 5'h1F;
      f  = `LSX_FLAGS_RST;
      f[`LSX_CF] = am < bm;
      f[`LSX_ZF] = r == 32'h0000_0000;
      f[`LSX_SF] = r[hb];
      f[`LSX_OF] = (am[hb] != bm[hb]) && (r[hb] != am[hb]);
      f[`LSX_PF] = ~^r[7:0];
      f[`LSX_AF] = a[4] ^ b[4] ^ r[4];
      return f;
   endfunction

   // ----------------------------------------------------------------
   // Decode and datapath
   // ----------------------------------------------------------------
   state_t      state_q;
   state_t      state_d;
   logic [31:0] src_q;
   logic [31:0] dst_q;
   logic [31:0] cnt_dec;
   logic        cnt_nz;
   logic        cnt_zero;
   logic        taken;
   logic        is_loop;
   logic [31:0] src_base;
   logic [31:0] src_addr;
   logic [31:0] dst_addr;
   logic [31:0] step;
   logic        bound_out;
   logic        finish;

   assign is_loop = (i_op == OP_LOOP) || (i_op == OP_LOOP_WHILE_EQUAL) || (i_op == OP_LOOP_WHILE_NOT_EQUAL);
   assign finish  = state_q == S_DONE;

   always_comb begin
      cnt_dec = i_loop_count_reg - 32'h0000_0001;
      if (i_addr16) begin
         cnt_dec = {i_loop_count_reg[31:16], i_loop_count_reg[15:0] - 16'h0001};
      end
   end

   assign cnt_nz   = i_addr16 ? (cnt_dec[15:0] != 16'h0000) : (cnt_dec != 32'h0000_0000);
   assign cnt_zero = i_addr16 ? (i_loop_count_reg[15:0] == 16'h0000)
                              : (i_loop_count_reg == 32'h0000_0000);

   always_comb begin
      case (i_op)
         OP_LOOP:   taken = cnt_nz;
         OP_LOOP_WHILE_EQUAL:  taken = cnt_nz && i_zero_flag;
         OP_LOOP_WHILE_NOT_EQUAL: taken = cnt_nz && !i_zero_flag;
         OP_JCZ:    taken = cnt_zero;
         default:   taken = 1'b0;
      endcase
   end

   assign bound_out = ($signed(i_bound_val) < $signed(i_bound_lo)) ||
                      ($signed(i_bound_val) > $signed(i_bound_hi));

   always_comb begin
      case (i_seg_ovr)
         SEG_CODE:  src_base = i_code_segment_reg;
         SEG_STACK: src_base = i_stack_segment_reg;
         SEG_EXTRA: src_base = i_extra_segment_reg;
         SEG_AUXF:  src_base = i_aux_segment_f_reg;
         SEG_AUXG:  src_base = i_aux_segment_g_reg;
         default:   src_base = i_data_segment_reg;
      endcase
   end

   assign src_addr = src_base + i_source_index;
   assign dst_addr = i_extra_segment_reg + i_dest_index_reg;
   assign step     = size_step(i_size);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (i_start) begin
               case (i_op)
                  OP_SMOVE, OP_SCMP, OP_SLOAD: state_d = S_RSRC;
                  OP_SSCAN:                    state_d = S_RDST;
                  OP_SSTORE:                   state_d = S_WDST;
                  default:                     state_d = S_DONE;
               endcase
            end
         end
         S_RSRC: begin
            if (i_mem_ack) begin
               case (i_op)
                  OP_SMOVE: state_d = S_WDST;
                  OP_SCMP:  state_d = S_RDST;
                  default:  state_d = S_DONE;
               endcase
            end
         end
         S_RDST: begin
            if (i_mem_ack) begin
               state_d = S_DONE;
            end
         end
         S_WDST: begin
            if (i_mem_ack) begin
               state_d = S_DONE;
            end
         end
         S_DONE:  state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Memory port
   // ----------------------------------------------------------------
   // Registered from the next state, so a request rises one cycle after start
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mem_req  <= 1'b0;
         o_mem_we   <= 1'b0;
         o_mem_size <= SZ_BYTE;
         o_mem_addr <= `LSX_WORD_RST;
      end else begin
         o_mem_req  <= (state_d == S_RSRC) || (state_d == S_RDST) || (state_d == S_WDST);
         o_mem_we   <= state_d == S_WDST;
         o_mem_size <= i_size;
         o_mem_addr <= (state_d == S_RSRC) ? src_addr : dst_addr;
      end
   end

   // Captured only on entry; read data is gone once the ack cycle passes
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mem_wdata <= `LSX_WORD_RST;
      end else if (state_d == S_WDST && state_q != S_WDST) begin
         o_mem_wdata <= (i_op == OP_SMOVE) ? (i_mem_rdata & size_mask(i_size))
                                           : (i_accum_dword & size_mask(i_size));
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         src_q <= `LSX_WORD_RST;
         dst_q <= `LSX_WORD_RST;
      end else begin
         if (state_q == S_RSRC && i_mem_ack) begin
            src_q <= i_mem_rdata & size_mask(i_size);
         end
         if (state_q == S_RDST && i_mem_ack) begin
            dst_q <= i_mem_rdata & size_mask(i_size);
         end
      end
   end

   // ----------------------------------------------------------------
   // Results, one cycle after the done state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_done          <= 1'b0;
         o_branch        <= 1'b0;
         o_instr_pointer <= `LSX_WORD_RST;
      end else begin
         o_done   <= finish;
         o_branch <= finish && taken;
         if (finish) begin
            o_instr_pointer <= taken ? i_instr_pointer + i_disp : i_instr_pointer;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_loop_count_reg <= `LSX_WORD_RST;
         o_count_we       <= 1'b0;
      end else begin
         o_count_we <= finish && is_loop;
         if (finish) begin
            o_loop_count_reg <= cnt_dec;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_flags    <= `LSX_FLAGS_RST;
         o_flags_we <= 1'b0;
      end else begin
         o_flags_we <= finish && ((i_op == OP_SCMP) || (i_op == OP_SSCAN));
         if (finish && i_op == OP_SCMP) begin
            o_flags <= sub_flags(src_q, dst_q, i_size);
         end else if (finish && i_op == OP_SSCAN) begin
            o_flags <= sub_flags(i_accum_dword, dst_q, i_size);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_accum_dword <= `LSX_WORD_RST;
         o_accum_we    <= 1'b0;
      end else begin
         o_accum_we <= finish && (i_op == OP_SLOAD);
         if (finish) begin
            o_accum_dword <= (i_accum_dword & ~size_mask(i_size)) | src_q;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_exc        <= 1'b0;
         o_exc_vector <= `LSX_VEC_RST;
      end else begin
         o_exc <= finish && ((i_op == OP_SWINT) ||
                             (i_op == OP_TRAPOVF && i_overflow_flag) ||
                             (i_op == OP_RANGE && bound_out));
         if (finish) begin
            case (i_op)
               OP_TRAPOVF: o_exc_vector <= `LSX_OVF_VECTOR;
               OP_RANGE:   o_exc_vector <= `LSX_BND_VECTOR;
               default:    o_exc_vector <= i_vector;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_source_index   <= `LSX_WORD_RST;
         o_dest_index_reg <= `LSX_WORD_RST;
         o_src_we         <= 1'b0;
         o_dst_we         <= 1'b0;
      end else begin
         o_src_we <= finish && ((i_op == OP_SMOVE) || (i_op == OP_SCMP) ||
                                (i_op == OP_SLOAD));
         o_dst_we <= finish && ((i_op == OP_SMOVE) || (i_op == OP_SCMP) ||
                                (i_op == OP_SSCAN) || (i_op == OP_SSTORE));
         if (finish) begin
            o_source_index   <= i_direction_flag ? i_source_index - step
                                                 : i_source_index + step;
            o_dest_index_reg <= i_direction_flag ? i_dest_index_reg - step
                                                 : i_dest_index_reg + step;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_move_start;
      state_q == S_IDLE && i_start && i_op == OP_SMOVE;
   endsequence

   sequence s_src_read;
      o_mem_req && !o_mem_we && o_mem_addr == src_addr;
   endsequence

   a_loop_count_dec: assert property (o_count_we && !i_addr16 |->
      o_loop_count_reg == i_loop_count_reg - 32'h0000_0001)
      else $error("loop count not decremented");

   a_loop_zero_wrap: assert property (o_count_we && i_loop_count_reg == 32'h0 |->
      o_loop_count_reg[15:0] == 16'hFFFF)
      else $error("zero count did not wrap");

   a_loop_exit: assert property (o_done && is_loop && !cnt_nz |->
      !o_branch && o_instr_pointer == i_instr_pointer)
      else $error("loop did not fall through");

   a_branch_target: assert property (o_branch |->
      o_instr_pointer == i_instr_pointer + i_disp)
      else $error("wrong branch target");

   a_loop_while_equal_cond: assert property (o_done && i_op == OP_LOOP_WHILE_EQUAL |->
      o_branch == (cnt_nz && i_zero_flag))
      else $error("loop while equal decision wrong");

   a_loop_while_not_equal_cond: assert property (o_done && i_op == OP_LOOP_WHILE_NOT_EQUAL && i_zero_flag |->
      !o_branch)
      else $error("loop while not equal took branch");

   a_jcz_full: assert property (o_done && i_op == OP_JCZ && !i_addr16 |->
      o_branch == (i_loop_count_reg == 32'h0) && !o_count_we)
      else $error("count zero jump wrong");

   a_jcz_low16: assert property (o_done && i_op == OP_JCZ && i_addr16 |->
      o_branch == (i_loop_count_reg[15:0] == 16'h0))
      else $error("16-bit count zero jump wrong");

   a_swint_vec: assert property (state_q == S_DONE && i_op == OP_SWINT |=>
      o_exc && o_exc_vector == i_vector)
      else $error("software interrupt vector wrong");

   a_trap_ovf: assert property (o_done && i_op == OP_TRAPOVF |->
      o_exc == i_overflow_flag)
      else $error("overflow trap wrong");

   a_range_exc: assert property (o_done && i_op == OP_RANGE |->
      o_exc == bound_out && o_exc_vector == `LSX_BND_VECTOR)
      else $error("range check wrong");

   a_dst_segment: assert property (o_mem_req && o_mem_we |->
      o_mem_addr == i_extra_segment_reg + i_dest_index_reg)
      else $error("destination not in extra segment");

   a_move_order: assert property (s_move_start |=> s_src_read)
      else $error("move did not read source first");

   a_cmp_no_write: assert property (state_q != S_IDLE &&
      (i_op == OP_SCMP || i_op == OP_SSCAN) |-> !o_mem_we)
      else $error("compare or scan wrote memory");

   a_index_step: assert property (o_dst_we && !i_direction_flag |->
      o_dest_index_reg == i_dest_index_reg + step)
      else $error("destination index step wrong");

endmodule

// File: lsx_params.svh
// Constants for the loop, branch, trap and string execution unit
`ifndef LSX_PARAMS_SVH
`define LSX_PARAMS_SVH

// ----------------------------------------------------------------
// Exception vectors
// ----------------------------------------------------------------
`define LSX_OVF_VECTOR 8'h04
`define LSX_BND_VECTOR 8'h05

// ----------------------------------------------------------------
// Status flag positions in o_flags
// ----------------------------------------------------------------
`define LSX_CF 0
`define LSX_ZF 1
`define LSX_OF 2
`define LSX_SF 3
`define LSX_PF 4
`define LSX_AF 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSX_FLAGS_RST 6'h00
`define LSX_WORD_RST  32'h0000_0000
`define LSX_VEC_RST   8'h00
`define LSX_SIZE_RST  2'h0

`endif

// File: lsx_pkg.sv
// Types shared by the loop, branch, trap and string execution unit
package lsx_pkg;

   // ----------------------------------------------------------------
   // Operations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_LOOP    = 4'h0,
      OP_LOOP_WHILE_EQUAL   = 4'h1,
      OP_LOOP_WHILE_NOT_EQUAL  = 4'h2,
      OP_JCZ     = 4'h3,
      OP_SWINT   = 4'h4,
      OP_TRAPOVF = 4'h5,
      OP_RANGE   = 4'h6,
      OP_SMOVE   = 4'h7,
      OP_SCMP    = 4'h8,
      OP_SSCAN   = 4'h9,
      OP_SLOAD   = 4'hA,
      OP_SSTORE  = 4'hB
   } op_t;

   typedef enum logic [1:0] {
      SZ_BYTE  = 2'h0,
      SZ_WORD  = 2'h1,
      SZ_DWORD = 2'h2
   } elem_size_t;

   typedef enum logic [2:0] {
      SEG_DATA  = 3'h0,
      SEG_CODE  = 3'h1,
      SEG_STACK = 3'h2,
      SEG_EXTRA = 3'h3,
      SEG_AUXF  = 3'h4,
      SEG_AUXG  = 3'h5
   } seg_sel_t;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RSRC = 5'b00010,
      S_RDST = 5'b00100,
      S_WDST = 5'b01000,
      S_DONE = 5'b10000
   } state_t;

endpackage

// File: mem_model.sv
// Memory model answering the unit's element accesses
`timescale 1ns/10ps
module mem_model (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // Access port
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_lat,
   output logic             o_ack,
   output logic [31:0]      o_rdata
);
   logic [31:0] mem [logic [31:0]];
   logic [3:0]  wait_q;
   // Read data toggles outside ack, so stale data never looks valid
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ack   <= 1'b0;
         o_rdata <= 32'h0000_0000;
         wait_q  <= 4'h0;
      end else if (o_ack || !i_req) begin
         o_ack   <= 1'b0;
         o_rdata <= ~o_rdata;
         wait_q  <= 4'h0;
      end else if (wait_q >= i_lat) begin
         o_ack   <= 1'b1;
         o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 32'hDEAD_BEEF;
         if (i_we) begin
            mem[i_addr] = i_wdata;
         end
      end else begin
         wait_q  <= wait_q + 4'h1;
         o_rdata <= ~o_rdata;
      end
   end
endmodule

// File: tb.sv
// Self-checking bench for the loop, trap and string execution unit
`timescale 1ns/10ps
`include "lsx_params.svh"
module tb;
   import lsx_pkg::*;
   logic        i_clk, ack, req, we, done, br, cwe, awe, fwe, exc, swe, dwe;
   logic        i_rst_b = 1'b0, start = 1'b0, a16 = 1'b0, zf = 1'b0, ovf = 1'b0, df = 1'b0;
   op_t         op = OP_LOOP;
   elem_size_t  sz = SZ_BYTE;
   seg_sel_t    seg = SEG_DATA;
   logic [7:0]  vec = 8'h80, evec;
   logic [3:0]  lat = 4'h0;
   logic [31:0] disp = 32'hFFFF_FFF0, ip = 32'h0000_0100, cnt = 32'h0, bv = 32'h0;
   logic [31:0] si = 32'h40, di = 32'h80, acc = 32'h1234_ABCD;
   logic [31:0] blo = 32'hFFFF_FFFC, bhi = 32'h0000_000A;
   logic [31:0] sb [6] = '{32'h1000_0000, 32'h2000_0000, 32'h3000_0000,
                           32'h4000_0000, 32'h5000_0000, 32'h6000_0000};
   logic [31:0] rdata, addr, wdata, o_ip, o_cnt, o_acc, o_si, o_di;
   logic [5:0]  flags;
   logic [1:0]  msz;
   int          failures = 0, total_checks = 0, cycles = 0;

   loop_string_exec_unit loop_string_exec_unit_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_start(start), .i_op(op), .i_size(sz), .i_seg_ovr(seg), .i_addr16(a16),
      .i_vector(vec), .i_disp(disp), .i_instr_pointer(ip), .i_loop_count_reg(cnt),
      .i_zero_flag(zf), .i_overflow_flag(ovf), .i_direction_flag(df), .i_source_index(si),
      .i_dest_index_reg(di), .i_accum_dword(acc), .i_bound_val(bv), .i_bound_lo(blo),
      .i_bound_hi(bhi), .i_data_segment_reg(sb[0]), .i_code_segment_reg(sb[1]),
      .i_stack_segment_reg(sb[2]), .i_extra_segment_reg(sb[3]),
      .i_aux_segment_f_reg(sb[4]), .i_aux_segment_g_reg(sb[5]), .o_mem_req(req),
      .o_mem_we(we), .o_mem_size(msz), .o_mem_addr(addr), .o_mem_wdata(wdata),
      .i_mem_ack(ack), .i_mem_rdata(rdata), .o_done(done), .o_branch(br),
      .o_instr_pointer(o_ip), .o_loop_count_reg(o_cnt), .o_count_we(cwe),
      .o_accum_dword(o_acc), .o_accum_we(awe), .o_flags(flags), .o_flags_we(fwe),
      .o_exc(exc), .o_exc_vector(evec), .o_source_index(o_si), .o_src_we(swe),
      .o_dest_index_reg(o_di), .o_dst_we(dwe));

   mem_model mem_model_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .i_we(we),
      .i_addr(addr), .i_wdata(wdata), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));

   // ----------------------------------------------------------------
   // Clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Whole run is well under a thousand cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Inputs stay put until the done pulse, as the unit does not latch them
   task automatic go(input op_t o);
      int n;
      start <= 1'b1;
      op    <= o;
      @(posedge i_clk);
      start <= 1'b0;
      #1;
      for (n = 0; n < 60 && done !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      chk(done, 1'b1);
   endtask
   task automatic lp(input op_t o, input logic a, input logic z, input logic [31:0] c,
                     input logic [31:0] ec, input logic eb);
      @(posedge i_clk);
      a16 <= a;
      zf  <= z;
      cnt <= c;
      go(o);
      chk(br, eb);
      chk(o_ip, eb ? 32'h0000_00F0 : 32'h0000_0100);
      chk(cwe, o != OP_JCZ);
      if (o != OP_JCZ) chk(o_cnt, ec);
   endtask
   task automatic tr(input op_t o, input logic ov, input logic [31:0] v, input logic ee,
                     input logic [7:0] ev);
      @(posedge i_clk);
      ovf <= ov;
      bv  <= v;
      go(o);
      chk(exc, ee);
      if (ee) chk(evec, ev);
   endtask
   // Each string call lengthens memory latency to mix prompt and slow answers
   task automatic st(input op_t o, input elem_size_t s, input seg_sel_t g, input logic d);
      @(posedge i_clk);
      sz  <= s;
      seg <= g;
      df  <= d;
      lat <= lat + 4'h1;
      go(o);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      lp(OP_LOOP, 1'b0, 1'b0, 32'h5, 32'h4, 1'b1);
      lp(OP_LOOP, 1'b0, 1'b0, 32'h1, 32'h0, 1'b0);
      lp(OP_LOOP, 1'b0, 1'b0, 32'h0, 32'hFFFF_FFFF, 1'b1);
      lp(OP_LOOP, 1'b1, 1'b0, 32'h1234_0000, 32'h1234_FFFF, 1'b1);
      lp(OP_LOOP, 1'b1, 1'b0, 32'h0001_0001, 32'h0001_0000, 1'b0);
      lp(OP_LOOP_WHILE_EQUAL, 1'b0, 1'b1, 32'h3, 32'h2, 1'b1);
      lp(OP_LOOP_WHILE_EQUAL, 1'b0, 1'b0, 32'h3, 32'h2, 1'b0);
      lp(OP_LOOP_WHILE_EQUAL, 1'b0, 1'b1, 32'h1, 32'h0, 1'b0);
      lp(OP_LOOP_WHILE_NOT_EQUAL, 1'b0, 1'b0, 32'h3, 32'h2, 1'b1);
      lp(OP_LOOP_WHILE_NOT_EQUAL, 1'b0, 1'b1, 32'h3, 32'h2, 1'b0);
      lp(OP_JCZ, 1'b0, 1'b0, 32'h0, 32'h0, 1'b1);
      lp(OP_JCZ, 1'b0, 1'b0, 32'h1_0000, 32'h0, 1'b0);
      lp(OP_JCZ, 1'b1, 1'b0, 32'h1_0000, 32'h0, 1'b1);
      tr(OP_SWINT, 1'b0, 32'h0, 1'b1, 8'h80);
      tr(OP_TRAPOVF, 1'b1, 32'h0, 1'b1, `LSX_OVF_VECTOR);
      tr(OP_TRAPOVF, 1'b0, 32'h0, 1'b0, 8'h00);
      tr(OP_RANGE, 1'b0, 32'hFFFF_FFFB, 1'b1, `LSX_BND_VECTOR);
      tr(OP_RANGE, 1'b0, 32'h0000_000B, 1'b1, `LSX_BND_VECTOR);
      tr(OP_RANGE, 1'b0, 32'h0000_000A, 1'b0, 8'h00);
      tr(OP_RANGE, 1'b0, 32'hFFFF_FFFC, 1'b0, 8'h00);
      mem_model_i.mem[32'h5000_0040] = 32'hCAFE_1234;
      mem_model_i.mem[32'h1000_0040] = 32'h0000_0077;
      mem_model_i.mem[32'h3000_0040] = 32'h0000_0001;
      st(OP_SMOVE, SZ_DWORD, SEG_AUXF, 1'b0);
      chk(mem_model_i.mem[32'h4000_0080], 32'hCAFE_1234);
      chk({swe, dwe}, 2'h3);
      chk(o_si, 32'h44);
      chk(o_di, 32'h84);
      st(OP_SLOAD, SZ_BYTE, SEG_DATA, 1'b1);
      chk(awe, 1'b1);
      chk(o_acc, 32'h1234_AB77);
      chk(o_si, 32'h3F);
      st(OP_SSTORE, SZ_WORD, SEG_CODE, 1'b0);
      chk(mem_model_i.mem[32'h4000_0080], 32'h0000_ABCD);
      chk(o_di, 32'h82);
      st(OP_SCMP, SZ_BYTE, SEG_STACK, 1'b0);
      chk({fwe, flags}, {1'b1, 6'h21});
      chk(mem_model_i.mem[32'h4000_0080], 32'h0000_ABCD);
      st(OP_SSCAN, SZ_WORD, SEG_DATA, 1'b0);
      chk({fwe, awe, flags}, {2'h2, 6'h12});
      chk(msz, SZ_WORD);
      mem_model_i.mem[32'h4000_0080] = 32'h8000_0000;
      st(OP_SSCAN, SZ_DWORD, SEG_DATA, 1'b0);
      chk(flags, 6'h0D);
      mem_model_i.mem[32'h6000_0040] = 32'h8765_4321;
      st(OP_SLOAD, SZ_DWORD, SEG_AUXG, 1'b0);
      chk(o_acc, 32'h8765_4321);
      mem_model_i.mem[32'h4000_0040] = 32'h0000_5A5A;
      st(OP_SLOAD, SZ_WORD, SEG_EXTRA, 1'b1);
      chk(o_acc, 32'h1234_5A5A);
      chk(o_si, 32'h3E);
      results();
   end
endmodule
